// *** rtl/dic_top.sv ***
// dsp idle control and clock mode switch register block, axi4-lite slave
// Summary of operation
// - request bit 5 set asks the dsp memory interface to idle
// - request bit 4 set asks the dsp pll to idle
// - request bit 3 set asks the dsp peripherals to idle
// - request bit 2 set asks the dsp instruction cache to idle
// - request bit 1 set asks the dsp dma controller to idle
// - request bit 0 set asks dsp core and its rams to idle
// - six request bits read and write, reset to zero; bits 15-6 reserved zero
// - state register bits 5-0 show which subdomains reached idle, same positions
// - state bits read only, zero after reset, one only while idle
// - request register shows which subdomains software asked to idle
`timescale 1ns/1ns
`default_nettype none
module dic_top import dic_pkg::*; #(
   parameter int AW = 8,
   parameter int QUIET = DIC_QUIET_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // axi4-lite write address and data
   input wire logic [AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // idle requests to the dsp subdomains
   output logic memifIdleReq,
   output logic pllIdleReq,
   output logic periphIdleReq,
   output logic cacheIdleReq,
   output logic dmaIdleReq,
   output logic coreIdleReq,
   // idle acknowledges from the dsp subdomains
   input wire logic memifIdleAck,
   input wire logic pllIdleAck,
   input wire logic periphIdleAck,
   input wire logic cacheIdleAck,
   input wire logic dmaIdleAck,
   input wire logic coreIdleAck,
   // clock mode
   output logic scalableRatioMode,
   output logic quietBusy
);
   typedef struct packed {
      dic_wr_t wrState;
      dic_rd_t rdState;
      logic awready;
      logic awHeld;
      logic [AW-1:0] awAddr;
      logic wready;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] sysState;
   } dic_top_t;

   dic_top_t s;
   dic_top_t next_s;
   logic [DIC_IDLE_BITS-1:0] reqBits;
   logic [DIC_IDLE_BITS-1:0] stateBits;
   logic [DIC_IDLE_BITS-1:0] ackBits;
   logic [5:0] wIdx;
   logic [5:0] rIdx;
   logic [15:0] wMerged;
   logic wrCommit;
   logic icrWe;
   logic sysWe;
   logic modeNow;
   logic busyNow;

   // gather the acknowledges into one vector, bit positions as requests
   assign ackBits = {memifIdleAck, pllIdleAck, periphIdleAck,
                     cacheIdleAck, dmaIdleAck, coreIdleAck};

   // word index of each address; low two bits are ignored
   assign wIdx = 6'(s.awAddr[AW-1:2]);
   assign rIdx = 6'(araddr[AW-1:2]);

   // a write commits once both address and data are held
   assign wrCommit = (s.wrState == DIC_WR_IDLE) && s.awHeld && s.wHeld;

   // only the two low byte lanes carry register data
   assign wMerged = {s.wStrb[1] ? s.wData[15:8] : s.sysState[15:8],
                     s.wStrb[0] ? s.wData[7:0] : s.sysState[7:0]};

   // request bits live in the low lane; a write without it leaves them alone
   assign icrWe = wrCommit && (wIdx == DIC_IDX_IDLE_REQ) && s.wStrb[0];
   assign sysWe = wrCommit && (wIdx == DIC_IDX_SYS_STATE) && (s.wStrb[1:0] != 2'h0);

   // request and state bits of the six subdomains
   dic_idle_track #(
      .N(DIC_IDLE_BITS)
   ) u_track (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .reqWe(icrWe),
      .reqData(s.wData[DIC_IDLE_BITS-1:0]),
      .ackIn(ackBits),
      .idleReq(reqBits),
      .idleState(stateBits)
   );

   // applied clock mode and the quiet window that follows a switch
   dic_quiet_timer #(
      .CYCLES(QUIET)
   ) u_quiet (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .modeWe(sysWe),
      .modeIn(wMerged[DIC_BIT_SCALABLE]),
      .modeOut(modeNow),
      .busy(busyNow)
   );

   // bus channels and the system state register
   always_comb begin
      next_s = s;
      // address and data are taken in either order
      if (awvalid && s.awready) begin
         next_s.awHeld = 1'b1;
         next_s.awAddr = awaddr;
      end
      if (wvalid && s.wready) begin
         next_s.wHeld = 1'b1;
         next_s.wData = wdata;
         next_s.wStrb = wstrb;
      end
      // commit the write and raise the response
      if (wrCommit) begin
         next_s.awHeld = 1'b0;
         next_s.wHeld = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.wrState = DIC_WR_RESP;
         case (wIdx)
            DIC_IDX_IDLE_REQ: next_s.bresp = DIC_RESP_OKAY;
            // writes to read-only state are dropped without error
            DIC_IDX_IDLE_STATE: next_s.bresp = DIC_RESP_OKAY;
            DIC_IDX_MODE_STATUS: next_s.bresp = DIC_RESP_OKAY;
            DIC_IDX_SYS_STATE: begin
               next_s.bresp = DIC_RESP_OKAY;
               next_s.sysState = wMerged;
            end
            default: next_s.bresp = DIC_RESP_SLVERR;
         endcase
      end else if ((s.wrState == DIC_WR_RESP) && bready) begin
         next_s.bvalid = 1'b0;
         next_s.wrState = DIC_WR_IDLE;
      end
      // read: capture data at the address handshake
      case (s.rdState)
         DIC_RD_IDLE: begin
            if (arvalid && s.arready) begin
               next_s.rvalid = 1'b1;
               next_s.rdState = DIC_RD_DATA;
               next_s.rresp = DIC_RESP_OKAY;
               case (rIdx)
                  DIC_IDX_IDLE_REQ: next_s.rdata = 32'(reqBits);
                  DIC_IDX_IDLE_STATE: next_s.rdata = 32'(stateBits);
                  DIC_IDX_MODE_STATUS: begin
                     next_s.rdata = 32'h0000_0000;
                     next_s.rdata[DIC_BIT_MS_MODE] = modeNow;
                     next_s.rdata[DIC_BIT_MS_QUIET] = busyNow;
                  end
                  DIC_IDX_SYS_STATE: next_s.rdata = 32'(s.sysState);
                  default: begin
                     next_s.rdata = 32'h0000_0000;
                     next_s.rresp = DIC_RESP_SLVERR;
                  end
               endcase
            end
         end
         DIC_RD_DATA: begin
            if (rready) begin
               next_s.rvalid = 1'b0;
               next_s.rdState = DIC_RD_IDLE;
            end
         end
         default: next_s.rdState = DIC_RD_IDLE;
      endcase
      // readies are registered so the bus sees them straight from flops
      next_s.awready = !next_s.awHeld && (next_s.wrState == DIC_WR_IDLE);
      next_s.wready = !next_s.wHeld && (next_s.wrState == DIC_WR_IDLE);
      next_s.arready = (next_s.rdState == DIC_RD_IDLE);
   end

   // register the bus state; readies open one cycle after reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s <= '0;
         s.sysState <= DIC_RST_SYS_STATE;
      end else begin
         s <= next_s;
      end
   end

   // bus outputs
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;

   // subdomain requests come straight from the request flops
   assign memifIdleReq = reqBits[DIC_BIT_MEMIF];
   assign pllIdleReq = reqBits[DIC_BIT_PLL];
   assign periphIdleReq = reqBits[DIC_BIT_PERIPH];
   assign cacheIdleReq = reqBits[DIC_BIT_CACHE];
   assign dmaIdleReq = reqBits[DIC_BIT_DMA];
   assign coreIdleReq = reqBits[DIC_BIT_CORE];

   // the quiet window is only reported; traffic is assumed absent during it
   assign scalableRatioMode = modeNow;
   assign quietBusy = busyNow;

   // checks on the idle request outputs
   memif_req_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      icrWe |=> memifIdleReq == $past(s.wData[DIC_BIT_MEMIF]))
      else $error("memory interface request does not follow write");
   pll_req_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      icrWe |=> pllIdleReq == $past(s.wData[DIC_BIT_PLL]))
      else $error("pll request does not follow write");
   periph_req_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      icrWe |=> periphIdleReq == $past(s.wData[DIC_BIT_PERIPH]))
      else $error("peripheral request does not follow write");
   cache_req_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      icrWe |=> cacheIdleReq == $past(s.wData[DIC_BIT_CACHE]))
      else $error("cache request does not follow write");
   dma_req_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      icrWe |=> dmaIdleReq == $past(s.wData[DIC_BIT_DMA]))
      else $error("dma request does not follow write");
   core_req_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      icrWe |=> coreIdleReq == $past(s.wData[DIC_BIT_CORE]))
      else $error("core request does not follow write");

   // requests hold without a write and start cleared
   req_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !icrWe |=> $stable(reqBits))
      else $error("idle requests changed without a write");
   req_reset_a: assert property (@(posedge sys_clk)
      $rose(rst_n) |-> (reqBits == '0) && (stateBits == '0))
      else $error("idle bits not clear after reset");

   // state bits track the acknowledges in both directions
   state_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ackBits[DIC_BIT_CORE] |=> stateBits[DIC_BIT_CORE])
      else $error("core idle state missed");
   state_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !ackBits[DIC_BIT_MEMIF] |=> !stateBits[DIC_BIT_MEMIF])
      else $error("memory interface state stuck at idle");
   state_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (arvalid && arready && rIdx == DIC_IDX_IDLE_STATE)
      |=> rvalid && rdata == 32'($past(stateBits)))
      else $error("idle state read wrong");

   // mode switch and the quiet window
   mode_apply_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sysWe |=> scalableRatioMode == $past(wMerged[DIC_BIT_SCALABLE]) && quietBusy)
      else $error("clock mode not applied at write");
   quiet_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (sysWe ##1 !sysWe [*8]) |-> quietBusy)
      else $error("quiet window ended early");

   // main scenarios
   req_write_c: cover property (@(posedge sys_clk) disable iff (!rst_n) icrWe);
   mode_switch_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
      sysWe ##1 quietBusy [*3]);
   idle_cycle_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
      stateBits[DIC_BIT_CORE] ##1 !stateBits[DIC_BIT_CORE]);
   err_resp_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
      bvalid && bresp == DIC_RESP_SLVERR);
endmodule : dic_top
`default_nettype wire

// *** rtl/dic_pkg.sv ***
// shared constants and types for the dsp idle and clock mode block
package dic_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] DIC_IDX_IDLE_REQ = 6'h01;
   localparam logic [5:0] DIC_IDX_IDLE_STATE = 6'h02;
   localparam logic [5:0] DIC_IDX_MODE_STATUS = 6'h03;
   localparam logic [5:0] DIC_IDX_SYS_STATE = 6'h18;
   // idle request / idle state bit positions
   localparam int DIC_IDLE_BITS = 6;
   localparam int DIC_BIT_MEMIF = 5;
   localparam int DIC_BIT_PLL = 4;
   localparam int DIC_BIT_PERIPH = 3;
   localparam int DIC_BIT_CACHE = 2;
   localparam int DIC_BIT_DMA = 1;
   localparam int DIC_BIT_CORE = 0;
   // system state field: clock mode select
   localparam int DIC_BIT_SCALABLE = 12;
   // mode status fields
   localparam int DIC_BIT_MS_MODE = 0;
   localparam int DIC_BIT_MS_QUIET = 1;
   // reset values
   localparam logic [15:0] DIC_RST_IDLE_REQ = 16'h0000;
   localparam logic [15:0] DIC_RST_IDLE_STATE = 16'h0000;
   localparam logic [15:0] DIC_RST_SYS_STATE = 16'h0000;
   // quiet period after a mode-change write, in processor cycles
   localparam int DIC_QUIET_CYCLES = 100;
   // axi response codes
   localparam logic [1:0] DIC_RESP_OKAY = 2'h0;
   localparam logic [1:0] DIC_RESP_SLVERR = 2'h2;
   // bus channel states
   typedef enum logic [0:0] {
      DIC_WR_IDLE = 1'b0,
      DIC_WR_RESP = 1'b1
   } dic_wr_t;
   typedef enum logic [0:0] {
      DIC_RD_IDLE = 1'b0,
      DIC_RD_DATA = 1'b1
   } dic_rd_t;
endpackage : dic_pkg

// *** rtl/dic_idle_track.sv ***
// idle request bits and registered idle state of the dsp subdomains
`timescale 1ns/1ns
`default_nettype none
module dic_idle_track import dic_pkg::*; #(
   parameter int N = DIC_IDLE_BITS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // request register update
   input wire logic reqWe,
   input wire logic [N-1:0] reqData,
   // subdomain side
   input wire logic [N-1:0] ackIn,
   output logic [N-1:0] idleReq,
   output logic [N-1:0] idleState
);
   typedef struct packed {
      logic [N-1:0] req;
      logic [N-1:0] sts;
   } dic_track_t;
   dic_track_t s;
   dic_track_t next_s;
   logic [N-1:0] next_req;
   logic [N-1:0] next_sts;

   // one slice per subdomain
   for (genvar i = 0; i < N; i++) begin : g_bit
      assign next_req[i] = reqWe ? reqData[i] : s.req[i];
      // state follows the subdomain both ways, so it falls once idle is left
      assign next_sts[i] = ackIn[i];
   end

   // gather the next state
   always_comb begin
      next_s.req = next_req;
      next_s.sts = next_sts;
   end

   // all bits clear after reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s <= {DIC_RST_IDLE_REQ[N-1:0], DIC_RST_IDLE_STATE[N-1:0]};
      end else begin
         s <= next_s;
      end
   end

   assign idleReq = s.req;
   assign idleState = s.sts;
endmodule : dic_idle_track
`default_nettype wire

// *** rtl/dic_quiet_timer.sv ***
// applied clock mode and quiet period after a mode-change write
`timescale 1ns/1ns
`default_nettype none
module dic_quiet_timer import dic_pkg::*; #(
   parameter int CYCLES = DIC_QUIET_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // mode write
   input wire logic modeWe,
   input wire logic modeIn,
   // state
   output logic modeOut,
   output logic busy
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES);
   typedef struct packed {
      logic mode;
      logic busy;
      logic [CW-1:0] cnt;
   } dic_quiet_t;
   dic_quiet_t s;
   dic_quiet_t next_s;

   // mode takes effect at the write; the count only reports the quiet window
   always_comb begin
      next_s = s;
      if (modeWe) begin
         next_s.mode = modeIn;
         next_s.cnt = LOAD;
      end else if (s.cnt != '0) begin
         next_s.cnt = s.cnt - 1'b1;
      end
      next_s.busy = (next_s.cnt != '0);
   end

   // register the state
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign modeOut = s.mode;
   assign busy = s.busy;
endmodule : dic_quiet_timer
`default_nettype wire

// *** verif/dic_dsp_model.sv ***
// behavioural model of the dsp subdomains that answer the idle requests
`timescale 1ns/1ns
`default_nettype none
module dic_dsp_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // pace: 0 answers after one cycle, 1 after four
   input wire logic slow,
   // idle handshake, one bit for each subdomain
   input wire logic [5:0] idleReq,
   output logic [5:0] idleAck
);
   logic [5:0] pipe [4];

   // a subdomain drains its work before it admits to being idle, and resumes the same way
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pipe <= '{6'h00, 6'h00, 6'h00, 6'h00};
      end else begin
         pipe <= '{idleReq, pipe[0], pipe[1], pipe[2]};
      end
   end

   // slow pace stretches both entry and exit so state bits are seen lagging requests
   assign idleAck = slow ? pipe[3] : pipe[0];
endmodule : dic_dsp_model
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the dsp idle and clock mode register block
`timescale 1ns/1ns
`default_nettype none
module tb_top import dic_pkg::*;;
   localparam int QW = 10;
   localparam logic [7:0] A_REQ = {DIC_IDX_IDLE_REQ, 2'b00};
   localparam logic [7:0] A_STATE = {DIC_IDX_IDLE_STATE, 2'b00};
   localparam logic [7:0] A_MODE = {DIC_IDX_MODE_STATUS, 2'b00};
   localparam logic [7:0] A_SYS = {DIC_IDX_SYS_STATE, 2'b00};
   localparam logic [7:0] REGS [4] = '{A_REQ, A_STATE, A_MODE, A_SYS};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic slow = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, scalableRatioMode, quietBusy;
   wire [1:0] bresp;
   wire [1:0] rresp;
   wire [31:0] rdata;
   wire [5:0] idleOut;
   wire [5:0] ack;
   int nMismatch = 0;
   int cmpCount = 0;
   int run = 0;
   int quietLen = 0;
   int expReq = 0;

   dic_top #(.AW(8), .QUIET(QW)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .memifIdleReq(idleOut[5]), .pllIdleReq(idleOut[4]),
      .periphIdleReq(idleOut[3]), .cacheIdleReq(idleOut[2]), .dmaIdleReq(idleOut[1]),
      .coreIdleReq(idleOut[0]), .memifIdleAck(ack[5]), .pllIdleAck(ack[4]),
      .periphIdleAck(ack[3]), .cacheIdleAck(ack[2]), .dmaIdleAck(ack[1]), .coreIdleAck(ack[0]),
      .scalableRatioMode(scalableRatioMode), .quietBusy(quietBusy));

   dic_dsp_model i_dsp (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .idleReq(idleOut),
      .idleAck(ack));

   // 10 MHz clock
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   // length of each quiet window, sampled mid-cycle away from the flop updates
   always @(negedge sys_clk) begin
      if (quietBusy === 1'b1) begin
         run++;
      end else if (run != 0) begin
         quietLen = run;
         run = 0;
      end
   end

   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic give_verdict();
      if (nMismatch == 0 && cmpCount > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         nMismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // address and data offered together, each dropped once taken; bready held until the answer
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      logic pa, pw, ha, hw, hb;
      int n;
      pa = 1'b1;
      pw = 1'b1;
      hb = 1'b0;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!hb && n < 100) begin
         hb = bvalid;
         r = bresp;
         ha = pa && awready;
         hw = pw && wready;
         tick();
         if (ha) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (hw) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
         n++;
      end
      bready <= 1'b0;
      // let an edge pass so a following call never re-drives bready in the same step
      tick();
      chk(hb, 1'b1);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic pa, ha, hb;
      int n;
      pa = 1'b1;
      hb = 1'b0;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!hb && n < 100) begin
         hb = rvalid;
         d = rdata;
         r = rresp;
         ha = pa && arready;
         tick();
         if (ha) begin
            arvalid <= 1'b0;
            pa = 1'b0;
         end
         n++;
      end
      rready <= 1'b0;
      // let an edge pass so a following call never re-drives rready in the same step
      tick();
      chk(hb, 1'b1);
   endtask : axi_rd

   // write the request register, then check pins, read-back and settled state
   task automatic set_req(input logic [31:0] v);
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(A_REQ, v, 4'h3, r);
      expReq = int'(v[5:0]);
      chk(r, DIC_RESP_OKAY);
      chk(idleOut, expReq);
      axi_rd(A_REQ, d, r);
      chk(r, DIC_RESP_OKAY);
      chk(d, expReq);
      repeat (8) tick();
      axi_rd(A_STATE, d, r);
      chk(d, expReq);
   endtask : set_req

   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      void'($urandom(26850));
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) tick();
      chk({quietBusy, scalableRatioMode, idleOut}, 0);
      for (int i = 0; i < 4; i++) begin
         axi_rd(REGS[i], d, r);
         chk(d, 0);
      end
      // each subdomain alone, reserved bits written high, paces alternating, slow pace on the odd bits
      for (int i = 0; i < 6; i++) begin
         slow <= i[0];
         set_req(32'hffc0 | (32'h1 << i));
      end
      set_req(32'h0);
      for (int i = 0; i < 8; i++) begin
         slow <= 1'($urandom);
         set_req($urandom);
      end
      // state register ignores writes
      axi_wr(A_STATE, ~expReq, 4'h3, r);
      chk(r, DIC_RESP_OKAY);
      axi_rd(A_STATE, d, r);
      chk(d, expReq);
      // holes in the map answer with an error
      axi_rd(8'h10, d, r);
      chk(r, DIC_RESP_SLVERR);
      chk(d, 32'h0);
      axi_wr(8'hfc, 32'h3f, 4'h3, r);
      chk(r, DIC_RESP_SLVERR);
      // dsp domains back at work and no bus transfer open before a switch; host caches sit outside
      set_req(32'h0);
      // into scalable mode and back; pll and dividers sit outside this block
      for (int m = 0; m < 2; m++) begin
         axi_wr(A_SYS, m ? 32'h0 : 32'h1000, 4'h3, r);
         chk(scalableRatioMode, !m);
         chk(quietBusy, 1'b1);
         repeat (QW + 2) tick();
         chk(quietLen, QW);
         axi_rd(A_MODE, d, r);
         chk(d, !m);
         axi_rd(A_SYS, d, r);
         chk(d, m ? 32'h0 : 32'h1000);
      end
      // a write with no lanes enabled must not count as a mode change
      axi_wr(A_SYS, 32'h1000, 4'h0, r);
      tick();
      chk({r, quietBusy, scalableRatioMode}, {DIC_RESP_OKAY, 2'b00});
      give_verdict();
   end

   // cut a hang short well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge sys_clk);
      nMismatch++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
